// File: lhi_host_port.sv
/*
 * Host port of a 2-line by 16-character display controller: register
 * select / read-write / enable bus, instruction and data holding registers,
 * address counter, text memory, glyph lookup for the display scan.
 * Assumes pins are synchronous to clk_in and that the enable strobe stays
 * high for at least two clock cycles.
 */
module lhi_host_port #(
    parameter int BUSY_CYCLES = lhi_pkg::EXEC_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic reg_select_line_in,
    input wire logic rw_in,
    input wire logic [lhi_pkg::DATA_W-1:0] data_in,
    output logic [lhi_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n_out,
    input wire logic font_tall_in,
    input wire logic scan_line_in,
    input wire logic [3:0] scan_pos_in,
    input wire logic [3:0] scan_row_in,
    output logic [lhi_pkg::DOTS_W-1:0] dots_out,
    output logic busy_indicator_out
);
    import lhi_pkg::*;

    generate
        if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_bad_busy
            $error("BUSY_CYCLES must lie in 1..65535");
        end
    endgenerate

    typedef enum {
        ST_IDLE,
        ST_DECODE,
        ST_EXEC,
        ST_CLEAR,
        ST_STORE,
        ST_FETCH
    } lhi_state_t;

    lhi_state_t state;
    lhi_state_t next_state;
    logic en_q;
    logic en_rise;
    logic en_fall;
    logic instr_take;
    logic data_take;
    logic data_read_done;
    logic busy_indicator;
    logic [DATA_W-1:0] instruction_register;
    logic [DATA_W-1:0] data_holding_register;
    logic [AC_W-1:0] addr_counter;
    logic [AC_W-1:0] next_ac;
    logic sel_glyph;
    logic [15:0] exec_cnt;
    logic [6:0] clr_idx;
    logic [DATA_W-1:0] display_text_ram [TEXT_DEPTH];
    logic [6:0] host_idx;
    logic host_valid;
    logic [DATA_W-1:0] host_byte;
    logic [6:0] scan_idx;

    lhi_glyph_if gif ();

    lhi_glyph_gen u_glyph (
        .clk_in(clk_in),
        .gif(gif)
    );

    // text address to memory index; each line is a 40-byte window
    function automatic logic [6:0] text_index(input logic [AC_W-1:0] a);
        return a[6] ? (LINE_LEN + {1'b0, a[5:0]}) : {1'b0, a[5:0]};
    endfunction : text_index

    function automatic logic [AC_W-1:0] text_step(input logic [AC_W-1:0] a);
        logic [AC_W-1:0] r;
        r = a + 7'h01;
        if (a[5:0] >= LINE_LEN[5:0] - 6'h01) begin
            r = a[6] ? RESET_AC : LINE2_BASE;
        end
        return r;
    endfunction : text_step

    // strobe edges; the enable pin is taken as synchronous
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_in;
        end
    end

    assign en_rise = en_in & ~en_q;
    assign en_fall = en_q & ~en_in;
    assign busy_indicator = (state != ST_IDLE);
    assign busy_indicator_out = busy_indicator;
    // writes while busy are dropped rather than queued
    assign instr_take = en_fall & ~rw_in & ~reg_select_line_in & ~busy_indicator;
    assign data_take = en_fall & ~rw_in & reg_select_line_in & ~busy_indicator;
    assign data_read_done = en_fall & rw_in & reg_select_line_in & ~busy_indicator;

    assign host_idx = text_index(addr_counter);
    assign host_valid = addr_counter[5:0] < LINE_LEN[5:0];
    assign next_ac = sel_glyph ? {1'b0, addr_counter[5:0] + 6'h01}
                               : text_step(addr_counter);

    always_comb begin
        if (sel_glyph) begin
            host_byte = gif.host_rdata;
        end else if (host_valid) begin
            host_byte = display_text_ram[host_idx];
        end else begin
            host_byte = RESET_BYTE;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (instr_take) begin
                    next_state = ST_DECODE;
                end else if (data_take) begin
                    next_state = ST_STORE;
                end else if (data_read_done) begin
                    next_state = ST_FETCH;
                end
            end
            ST_DECODE: begin
                if (instruction_register[CMD_TEXT_ADDR_BIT]
                    || instruction_register[CMD_GLYPH_ADDR_BIT]) begin
                    next_state = ST_FETCH;
                end else if (instruction_register == CMD_CLEAR) begin
                    next_state = ST_CLEAR;
                end else begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (exec_cnt == 16'h0000) begin
                    next_state = ST_IDLE;
                end
            end
            ST_CLEAR: begin
                if (clr_idx == TEXT_DEPTH[6:0] - 7'h01) begin
                    next_state = ST_FETCH;
                end
            end
            ST_STORE: next_state = ST_FETCH;
            ST_FETCH: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // only the host loads it, and no read path returns it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            instruction_register <= RESET_BYTE;
        end else if (instr_take) begin
            instruction_register <= data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            exec_cnt <= 16'h0000;
        end else if (state == ST_DECODE) begin
            exec_cnt <= 16'(BUSY_CYCLES - 1);
        end else if (state == ST_EXEC && exec_cnt != 16'h0000) begin
            exec_cnt <= exec_cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clr_idx <= 7'h00;
        end else if (state == ST_CLEAR) begin
            clr_idx <= clr_idx + 7'h01;
        end else begin
            clr_idx <= 7'h00;
        end
    end

    // one counter addresses both memories; sel_glyph says which
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_counter <= RESET_AC;
            sel_glyph <= 1'b0;
        end else if (state == ST_DECODE) begin
            if (instruction_register[CMD_TEXT_ADDR_BIT]) begin
                addr_counter <= instruction_register[6:0];
                sel_glyph <= 1'b0;
            end else if (instruction_register[CMD_GLYPH_ADDR_BIT]) begin
                addr_counter <= {1'b0, instruction_register[5:0]};
                sel_glyph <= 1'b1;
            end else if (instruction_register == CMD_CLEAR) begin
                addr_counter <= RESET_AC;
                sel_glyph <= 1'b0;
            end
        end else if (state == ST_STORE || (state == ST_IDLE && data_read_done)) begin
            addr_counter <= next_ac;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_holding_register <= RESET_BYTE;
        end else if (data_take) begin
            data_holding_register <= data_in;
        end else if (state == ST_FETCH) begin
            data_holding_register <= host_byte;
        end
    end

    // memory array has no reset; clear fills it with blanks instead
    always_ff @(posedge clk_in) begin
        if (state == ST_CLEAR) begin
            display_text_ram[clr_idx] <= BLANK_CODE;
        end else if (state == ST_STORE && !sel_glyph && host_valid) begin
            display_text_ram[host_idx] <= data_holding_register;
        end
    end

    assign gif.host_wr = (state == ST_STORE) && sel_glyph;
    assign gif.host_addr = addr_counter[GLYPH_AW-1:0];
    assign gif.host_wdata = data_holding_register;

    // the byte is latched at the strobe's rising edge and held to its end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_out <= RESET_BYTE;
        end else if (en_rise && rw_in) begin
            if (reg_select_line_in) begin
                data_out <= data_holding_register;
            end else begin
                data_out <= {busy_indicator, addr_counter};
            end
        end
    end

    assign data_oe_n_out = ~(en_in & rw_in);

    assign scan_idx = scan_line_in ? (LINE_LEN + {3'h0, scan_pos_in})
                                   : {3'h0, scan_pos_in};
    assign gif.code = display_text_ram[scan_idx];
    assign gif.dot_row = scan_row_in;
    assign gif.tall = font_tall_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dots_out <= '0;
        end else begin
            dots_out <= gif.dots;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_addr_instr;
        state == ST_DECODE && instruction_register[CMD_TEXT_ADDR_BIT];
    endsequence

    sequence s_prefetch;
        state == ST_FETCH ##1 data_holding_register == $past(host_byte);
    endsequence

    a_busy_blocks_instr: assert property (
        busy_indicator && en_fall && !rw_in && !reg_select_line_in
        |=> instruction_register == $past(instruction_register) && state != ST_DECODE
    ) else $error("instruction taken while busy");

    a_instr_captured: assert property (
        instr_take |=> instruction_register == $past(data_in) && state == ST_DECODE
    ) else $error("instruction not captured");

    a_status_byte: assert property (
        en_rise && rw_in && !reg_select_line_in
        |=> data_out == {$past(busy_indicator), $past(addr_counter)}
    ) else $error("status byte wrong");

    a_status_when_busy: assert property (
        busy_indicator && en_rise && rw_in && !reg_select_line_in |=> data_out[7]
    ) else $error("busy not shown in status");

    a_data_read_path: assert property (
        en_rise && rw_in && reg_select_line_in |=> data_out == $past(data_holding_register)
    ) else $error("data read does not return holding register");

    a_addr_prefetch: assert property (
        s_addr_instr |=> s_prefetch
    ) else $error("no prefetch after address write");

    a_data_write_path: assert property (
        data_take |=> data_holding_register == $past(data_in) ##1 state == ST_FETCH
    ) else $error("data write not staged");

    a_line_wrap: assert property (
        state == ST_STORE && !sel_glyph && addr_counter == 7'h27
        |=> addr_counter == LINE2_BASE
    ) else $error("line one does not wrap to line two");

    a_clear_done: assert property (
        state == ST_CLEAR && clr_idx == TEXT_DEPTH[6:0] - 7'h01
        |=> state == ST_FETCH && addr_counter == RESET_AC && !sel_glyph
    ) else $error("clear did not end after 80 bytes");

    a_drive_on_read: assert property (
        en_in && rw_in |-> !data_oe_n_out
    ) else $error("bus not driven during read");
endmodule : lhi_host_port

// File: lhi_pkg.sv
/*
 * Shared constants for the character display host port: sizes, address map
 * of the text memory, command codes and busy timing.
 * Assumes a 40 MHz system clock; all other files import this package.
 */
package lhi_pkg;
    localparam int DATA_W = 8;
    localparam int AC_W = 7;
    localparam int GLYPH_AW = 6;
    localparam int TEXT_DEPTH = 80;
    localparam int GLYPH_DEPTH = 64;
    localparam int DOTS_W = 5;
    localparam logic [6:0] LINE_LEN = 7'h28;
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [6:0] TEXT_LAST = 7'h4f;
    localparam logic [7:0] BLANK_CODE = 8'h20;
    localparam logic [7:0] CMD_CLEAR = 8'h01;
    localparam int CMD_TEXT_ADDR_BIT = 7;
    localparam int CMD_GLYPH_ADDR_BIT = 6;
    localparam logic [3:0] ROWS_SHORT = 4'h8;
    localparam logic [3:0] ROWS_TALL = 4'ha;
    localparam int CLK_PERIOD_NS = 25;
    // busy time of an ordinary instruction; only clear and the two address instructions are modelled
    localparam int EXEC_NS = 1000;
    localparam int EXEC_CYC = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] RESET_AC = 7'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : lhi_pkg

// File: lhi_glyph_if.sv
/*
 * Carrier between the host port and the glyph generator: host access to the
 * glyph RAM and the scan lookup of one dot row.
 * Assumes both ends run on the same clock.
 */
interface lhi_glyph_if;
    import lhi_pkg::*;
    logic host_wr;
    logic [GLYPH_AW-1:0] host_addr;
    logic [DATA_W-1:0] host_wdata;
    logic [DATA_W-1:0] host_rdata;
    logic [DATA_W-1:0] code;
    logic [3:0] dot_row;
    logic tall;
    logic [DOTS_W-1:0] dots;
    modport port (output host_wr, host_addr, host_wdata, code, dot_row, tall,
                  input host_rdata, dots);
    modport gen (input host_wr, host_addr, host_wdata, code, dot_row, tall,
                 output host_rdata, dots);
endinterface : lhi_glyph_if

// File: lhi_glyph_gen.sv
/*
 * Glyph generator: user-writable glyph RAM plus the fixed glyph ROM,
 * turning a character code and dot row into five dots.
 * Assumes the host port drives the carrier on the same clock.
 */
module lhi_glyph_gen (
    input wire logic clk_in,
    lhi_glyph_if.gen gif
);
    import lhi_pkg::*;

    logic [DATA_W-1:0] glyph_ram [GLYPH_DEPTH];
    logic user_code;
    logic [GLYPH_AW-1:0] scan_addr;
    logic row_ok;

    // stand-in font table; a production font replaces this function
    function automatic logic [DOTS_W-1:0] glyph_rom(input logic [7:0] c,
                                                    input logic [3:0] r);
        logic [DOTS_W-1:0] v;
        v = c[4:0] ^ {r, 1'b0};
        return (r == 4'h0) ? c[7:3] : v;
    endfunction : glyph_rom

    always_ff @(posedge clk_in) begin
        if (gif.host_wr) begin
            glyph_ram[gif.host_addr] <= gif.host_wdata;
        end
    end

    assign gif.host_rdata = glyph_ram[gif.host_addr];

    always_comb begin
        user_code = (gif.code[7:4] == 4'h0);
        row_ok = gif.dot_row < (gif.tall ? ROWS_TALL : ROWS_SHORT);
        // bit 3 of the code is ignored; tall glyphs use pairs of slots
        if (gif.tall) begin
            scan_addr = {gif.code[2:1], gif.dot_row};
        end else begin
            scan_addr = {gif.code[2:0], gif.dot_row[2:0]};
        end
        if (!row_ok) begin
            gif.dots = '0;
        end else if (user_code) begin
            gif.dots = glyph_ram[scan_addr][DOTS_W-1:0];
        end else begin
            gif.dots = glyph_rom(gif.code, gif.dot_row);
        end
    end
endmodule : lhi_glyph_gen

// File: lhi_host_model.sv
/*
 * Host processor model for the display host port: one strobe per byte,
 * register select and read/write held steady while the strobe is high.
 * Assumes the bench ties its outputs to the port's bus inputs.
 */
module lhi_host_model (
    input wire logic clk_in,
    output logic en_out,
    output logic rs_out,
    output logic rw_out,
    output logic [7:0] bus_out,
    input wire logic [7:0] bus_in,
    input wire logic oe_n_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import lhi_pkg::*;

    initial begin
        en_out = 1'b0;
        rs_out = 1'b0;
        rw_out = 1'b0;
        bus_out = 8'h00;
    end

    // strobe stays high two clocks, read data taken before release
    task automatic cycle(input logic rs, input logic rw, input logic [7:0] wb,
                         output logic [7:0] rb);
        @(negedge clk_in);
        en_out = 1'b1;
        rs_out = rs;
        rw_out = rw;
        if (!rw) begin
            bus_out = wb;
        end
        repeat (2) @(negedge clk_in);
        rb = (oe_n_in === 1'b0) ? bus_in : 8'hxx;
        en_out = 1'b0;
        // the port takes the byte at the edge that first sees the strobe low
        @(negedge clk_in);
        // a released bus does not keep the last byte
        bus_out = ~bus_out;
    endtask : cycle

    task automatic wr(input logic rs, input logic [7:0] wb);
        logic [7:0] d;
        cycle(rs, 1'b0, wb, d);
    endtask : wr

    task automatic rd(input logic rs, output logic [7:0] rb);
        cycle(rs, 1'b1, 8'h00, rb);
    endtask : rd

    // no further write until the busy bit reads back clear or 200 status reads have passed
    task automatic poll(output logic [7:0] st);
        st = 8'hff;
        for (int i = 0; i < 200 && st[7] !== 1'b0; i++) begin
            rd(1'b0, st);
        end
    endtask : poll
endmodule : lhi_host_model

// File: test_lhi_host_port.sv
/*
 * Self-checking bench for the display host port: host bus accesses,
 * text and glyph memory, scan lookup and busy refusal.
 * Assumes the design files and lhi_host_model are compiled first.
 */
module test_lhi_host_port;
    timeunit 1ns;
    timeprecision 1ps;
    import lhi_pkg::*;

    logic clk_in, rst_in, font_tall_in, scan_line_in, en, rs, rw, oe_n, busy;
    logic [3:0] scan_pos_in, scan_row_in;
    logic [7:0] hbus, dbus, r;
    logic [4:0] dots;
    int mismatches, checks_done;

    lhi_host_port #(.BUSY_CYCLES(4)) i_lhi_host_port (
        .clk_in(clk_in), .rst_in(rst_in), .en_in(en), .reg_select_line_in(rs),
        .rw_in(rw), .data_in(hbus), .data_out(dbus), .data_oe_n_out(oe_n),
        .font_tall_in(font_tall_in), .scan_line_in(scan_line_in),
        .scan_pos_in(scan_pos_in), .scan_row_in(scan_row_in), .dots_out(dots),
        .busy_indicator_out(busy)
    );

    lhi_host_model i_lhi_host_model (
        .clk_in(clk_in), .en_out(en), .rs_out(rs), .rw_out(rw), .bus_out(hbus),
        .bus_in(dbus), .oe_n_in(oe_n)
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic scan(input string name, input logic l, input logic [3:0] p,
                        input logic [3:0] row, input logic [4:0] exp);
        @(negedge clk_in);
        scan_line_in = l;
        scan_pos_in = p;
        scan_row_in = row;
        @(negedge clk_in);
        check(name, {3'h0, dots}, {3'h0, exp});
    endtask : scan

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // full run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        end_of_test();
    end

    initial begin
        rst_in = 1'b1;
        font_tall_in = 1'b0;
        scan_line_in = 1'b0;
        scan_pos_in = 4'h0;
        scan_row_in = 4'h0;
        mismatches = 0;
        checks_done = 0;
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        i_lhi_host_model.rd(1'b0, r);
        check("status after reset", r, {1'b0, RESET_AC});
        i_lhi_host_model.wr(1'b0, CMD_CLEAR);
        check("busy pin after clear", {7'h00, busy}, 8'h01);
        i_lhi_host_model.rd(1'b0, r);
        check("busy during clear", {7'h00, r[7]}, 8'h01);
        i_lhi_host_model.poll(r);
        check("status after clear", r, 8'h00);
        i_lhi_host_model.wr(1'b0, 8'h85);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.rd(1'b1, r);
        check("cleared cell", r, BLANK_CODE);
        $display("test clear done");

        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b0, 8'h80 | {1'b0, LINE2_BASE});
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b1, 8'h41);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b1, 8'h42);
        i_lhi_host_model.poll(r);
        check("counter after data writes", r, 8'h42);
        i_lhi_host_model.wr(1'b0, 8'h8f);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b1, 8'h5a);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b0, 8'hc0);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.rd(1'b1, r);
        check("prefetched text byte", r, 8'h41);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.rd(1'b1, r);
        check("next text byte", r, 8'h42);
        i_lhi_host_model.poll(r);
        check("counter after reads", r, 8'h42);
        i_lhi_host_model.wr(1'b0, 8'ha7);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b1, 8'h33);
        i_lhi_host_model.poll(r);
        check("counter wraps to line two", r, {1'b0, LINE2_BASE});
        scan("line two first cell", 1'b1, 4'h0, 4'h0, 5'h08);
        scan("line one last cell", 1'b0, 4'hf, 4'h0, 5'h0b);
        scan("rom second row", 1'b0, 4'hf, 4'h1, 5'h18);
        scan("row past short glyph", 1'b0, 4'hf, 4'h9, 5'h00);
        $display("test text done");

        i_lhi_host_model.wr(1'b0, 8'h40);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b1, 8'h15);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b1, 8'h0a);
        i_lhi_host_model.poll(r);
        check("glyph counter", r, 8'h02);
        i_lhi_host_model.wr(1'b0, 8'h41);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.rd(1'b1, r);
        check("glyph byte read", r, 8'h0a);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b0, 8'h81);
        i_lhi_host_model.poll(r);
        i_lhi_host_model.wr(1'b1, 8'h08);
        i_lhi_host_model.poll(r);
        scan("user glyph row 0", 1'b0, 4'h1, 4'h0, 5'h15);
        scan("user glyph row 1", 1'b0, 4'h1, 4'h1, 5'h0a);
        font_tall_in = 1'b1;
        scan("tall glyph row 0", 1'b0, 4'h1, 4'h0, 5'h15);
        scan("row past tall glyph", 1'b0, 4'h1, 4'ha, 5'h00);
        font_tall_in = 1'b0;
        $display("test glyph done");

        i_lhi_host_model.wr(1'b0, 8'h02);
        i_lhi_host_model.wr(1'b0, 8'h85);
        i_lhi_host_model.poll(r);
        check("address write while busy", r, 8'h02);
        i_lhi_host_model.wr(1'b0, 8'h02);
        i_lhi_host_model.wr(1'b1, 8'h77);
        i_lhi_host_model.poll(r);
        check("data write while busy", r, 8'h02);
        check("busy pin idle", {7'h00, busy}, 8'h00);
        $display("test busy done");
        end_of_test();
    end
endmodule : test_lhi_host_port
